// ### include/pgp_map.svh
// Address map, reset values and field masks of the port pin control block
`ifndef PGP_MAP_SVH
`define PGP_MAP_SVH
`define PGP_ADR_P0 16'hff00
`define PGP_ADR_P1 16'hff01
`define PGP_ADR_P2 16'hff02
`define PGP_ADR_P4 16'hff04
`define PGP_ADR_PM0 16'hff20
`define PGP_ADR_PM1 16'hff21
`define PGP_ADR_PM2 16'hff22
`define PGP_ADR_PM4 16'hff24
`define PGP_ADR_PORT_OPEN_DRAIN_REG 16'hff30
`define PGP_ADR_PIN_OPEN_DRAIN_REG 16'hff31
`define PGP_ADR_PU 16'hfff7
`define PGP_RST_PU 8'h00
`define PGP_RST_POM 8'h00
`define PGP_RST_DIR 8'hff
`define PGP_RST_LAT 8'h00
`define PGP_MSK_PU 8'h17
`define PGP_MSK_PORT_OPEN_DRAIN_REG 8'h03
`define PGP_MSK_PIN_OPEN_DRAIN_REG 8'h60
`define PGP_FIX_DIR2 8'h80
`define PGP_BIT_PU_P0 0
`define PGP_BIT_PU_P1 1
`define PGP_BIT_PU_P2 2
`define PGP_BIT_PU_P4 4
`define PGP_BIT_POM_P0 0
`define PGP_BIT_POM_P1 1
`endif

// ### include/pgp_pkg.sv
// Types and helper functions of the port pin control block
package pgp_pkg;

    typedef enum logic [2:0] {
        pgp_op_mov,
        pgp_op_set1,
        pgp_op_clr1,
        pgp_op_add,
        pgp_op_sub,
        pgp_op_and,
        pgp_op_or,
        pgp_op_xor
    } pgp_op_t;

    function automatic logic pgp_hit(input logic [15:0] adr, input logic [15:0] reg_adr);
        return adr == reg_adr;
    endfunction : pgp_hit

    // Value a read-modify-write starts from: latch where driven, pin where not
    function automatic logic [7:0] pgp_rmw_src(input logic [7:0] lat, input logic [7:0] dir,
                                               input logic [7:0] lvl);
        return (lat & ~dir) | (lvl & dir);
    endfunction : pgp_rmw_src

endpackage : pgp_pkg

// ### design/pgp_rmw_alu.sv
// Modify stage of byte, bit and arithmetic memory operations
`timescale 1ns/1ns
module pgp_rmw_alu import pgp_pkg::*; (
    input wire pgp_op_t op,         // Operation kind
    input wire logic [2:0] bit_idx, // Bit for set1/clr1
    input wire logic [7:0] src,     // Value read back
    input wire logic [7:0] operand, // Data from the CPU
    output logic [7:0] res          // Value to write
);
    wire [7:0] bit_msk = 8'h01 << bit_idx;

    always_comb begin
        unique case (op)
            pgp_op_mov: res = operand;
            pgp_op_set1: res = src | bit_msk;
            pgp_op_clr1: res = src & ~bit_msk;
            pgp_op_add: res = 8'(src + operand);
            pgp_op_sub: res = 8'(src - operand);
            pgp_op_and: res = src & operand;
            pgp_op_or: res = src | operand;
            pgp_op_xor: res = src ^ operand;
        endcase
    end
endmodule : pgp_rmw_alu

// ### design/pgp_port_cell.sv
// One 8-bit port: output latch, direction, pin synchroniser and pad drive
`timescale 1ns/1ns
`include "pgp_map.svh"
module pgp_port_cell import pgp_pkg::*; (
    input wire logic mclk,          // System clock
    input wire logic rst_b,         // Async reset, active low
    input wire logic lat_we,        // Latch write strobe
    input wire logic [7:0] lat_nxt, // Latch write value
    input wire logic dir_we,        // Direction write strobe
    input wire logic [7:0] dir_nxt, // Direction write value
    input wire logic [7:0] dir_fix, // Bits forced to input
    input wire logic [7:0] od_sel,  // Open-drain per pin
    input wire logic pu_en,         // Port pull-up enable
    input wire logic [7:0] pin_in,  // Pad levels
    output logic [7:0] lat_q,       // Output latch
    output logic [7:0] dir_q,       // Direction, 1 = input
    output logic [7:0] pin_lvl,     // Synchronised pad levels
    output logic [7:0] pin_out,     // Pad output value
    output logic [7:0] pin_oe,      // Pad output enable
    output logic [7:0] pin_pu       // Pad pull-up connect
);
    logic [7:0] lat_r;
    logic [7:0] dir_r;
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lat_r <= `PGP_RST_LAT;
            dir_r <= `PGP_RST_DIR;
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            if (lat_we) begin
                lat_r <= lat_nxt;
            end
            if (dir_we) begin
                dir_r <= dir_nxt | dir_fix;
            end
        end
    end

    assign lat_q = lat_r;
    assign dir_q = dir_r | dir_fix;
    assign pin_lvl = sync2_r;
    // Open drain never drives high; a 1 in the latch just releases the pad
    assign pin_out = lat_r & ~od_sel;
    assign pin_oe = ~dir_q & (~od_sel | ~lat_r);
    // Output mode never sees the pull-up
    assign pin_pu = {8{pu_en}} & dir_q;
endmodule : pgp_port_cell

// ### design/pgp_gpio.sv
// Port pin control: pull-ups, open-drain select, latches, memory access
// Overview of operation
// - Pull-up only on pins in input mode
// - Pull-up bit 1 connects, 0 disconnects
// - Reset clears pull-up enable register
// - Ports 0, 1 and two port2 pins open-drain capable
// - Port-level bit sets whole port drive type
// - Pin-level bits set port2 pins 5, 6
// - Reset clears both open-drain select registers
// - Output mode write loads latch, drives pins
// - Input mode write loads latch, pins unchanged
// - Port read returns pins, latch untouched
// - Bit set/clear is byte read-modify-write
// - Output mode arithmetic works on latch
// - Input mode arithmetic leaves latch undefined
// - Direction 0 drives, 1 floats; resets ones
`timescale 1ns/1ns
`include "pgp_map.svh"
module pgp_gpio import pgp_pkg::*; (
    input wire logic mclk,            // System clock, 10 MHz
    input wire logic rst_b,           // Async reset, active low
    input wire logic [15:0] cpu_addr, // Memory address
    input wire logic cpu_wr,          // Write or modify strobe
    input wire logic cpu_rd,          // Read strobe
    input wire pgp_op_t cpu_op,       // Kind of write
    input wire logic [2:0] cpu_bit,   // Bit for set1/clr1
    input wire logic [7:0] cpu_wdata, // Write data or operand
    output logic [7:0] cpu_rdata,     // Read data, one cycle late
    input wire logic [7:0] p0_in,     // Port 0 pad levels
    output logic [7:0] p0_out,        // Port 0 pad value
    output logic [7:0] p0_oe,         // Port 0 pad enable
    output logic [7:0] p0_pu,         // Port 0 pull-up
    input wire logic [7:0] p1_in,     // Port 1 pad levels
    output logic [7:0] p1_out,        // Port 1 pad value
    output logic [7:0] p1_oe,         // Port 1 pad enable
    output logic [7:0] p1_pu,         // Port 1 pull-up
    input wire logic [7:0] p2_in,     // Port 2 pad levels
    output logic [7:0] p2_out,        // Port 2 pad value
    output logic [7:0] p2_oe,         // Port 2 pad enable
    output logic [7:0] p2_pu,         // Port 2 pull-up
    input wire logic [7:0] p4_in,     // Port 4 pad levels
    output logic [7:0] p4_out,        // Port 4 pad value
    output logic [7:0] p4_oe,         // Port 4 pad enable
    output logic [7:0] p4_pu          // Port 4 pull-up
);
    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] pullup_enable_reg_r;
    logic [7:0] port_open_drain_reg_r;
    logic [7:0] pin_open_drain_reg_r;
    logic [7:0] cpu_rdata_r;

    logic [7:0] lat0, lat1, lat2, lat4;
    logic [7:0] dir0, dir1, dir2, dir4;
    logic [7:0] lvl0, lvl1, lvl2, lvl4;
    logic [7:0] mod_res;

    // ****************************************
    // Address decode
    // ****************************************
    wire hit_p0 = pgp_hit(cpu_addr, `PGP_ADR_P0);
    wire hit_p1 = pgp_hit(cpu_addr, `PGP_ADR_P1);
    wire hit_p2 = pgp_hit(cpu_addr, `PGP_ADR_P2);
    wire hit_p4 = pgp_hit(cpu_addr, `PGP_ADR_P4);
    wire hit_pm0 = pgp_hit(cpu_addr, `PGP_ADR_PM0);
    wire hit_pm1 = pgp_hit(cpu_addr, `PGP_ADR_PM1);
    wire hit_pm2 = pgp_hit(cpu_addr, `PGP_ADR_PM2);
    wire hit_pm4 = pgp_hit(cpu_addr, `PGP_ADR_PM4);
    wire hit_port_open_drain_reg = pgp_hit(cpu_addr, `PGP_ADR_PORT_OPEN_DRAIN_REG);
    wire hit_pin_open_drain_reg = pgp_hit(cpu_addr, `PGP_ADR_PIN_OPEN_DRAIN_REG);
    wire hit_pu = pgp_hit(cpu_addr, `PGP_ADR_PU);

    wire wr_p0 = cpu_wr & hit_p0;
    wire wr_p1 = cpu_wr & hit_p1;
    wire wr_p2 = cpu_wr & hit_p2;
    wire wr_p4 = cpu_wr & hit_p4;
    wire wr_pm0 = cpu_wr & hit_pm0;
    wire wr_pm1 = cpu_wr & hit_pm1;
    wire wr_pm2 = cpu_wr & hit_pm2;
    wire wr_pm4 = cpu_wr & hit_pm4;
    wire wr_port_open_drain_reg = cpu_wr & hit_port_open_drain_reg;
    wire wr_pin_open_drain_reg = cpu_wr & hit_pin_open_drain_reg;
    wire wr_pu = cpu_wr & hit_pu;

    // ****************************************
    // Read-modify-write source
    // ****************************************
    // The core reads the whole byte even for a one-bit op, so input-mode
    // pins pick up their pad level: the latch bit is effectively undefined.
    wire [7:0] src_p0 = pgp_rmw_src(lat0, dir0, lvl0);
    wire [7:0] src_p1 = pgp_rmw_src(lat1, dir1, lvl1);
    wire [7:0] src_p2 = pgp_rmw_src(lat2, dir2, lvl2);
    wire [7:0] src_p4 = pgp_rmw_src(lat4, dir4, lvl4);

    wire [7:0] mod_src = hit_p0 ? src_p0 :
                         hit_p1 ? src_p1 :
                         hit_p2 ? src_p2 :
                         hit_p4 ? src_p4 :
                         hit_pm0 ? dir0 :
                         hit_pm1 ? dir1 :
                         hit_pm2 ? dir2 :
                         hit_pm4 ? dir4 :
                         hit_port_open_drain_reg ? port_open_drain_reg_r :
                         hit_pin_open_drain_reg ? pin_open_drain_reg_r :
                         hit_pu ? pullup_enable_reg_r : 8'h00;

    // Ports read the pads, never the latch
    wire [7:0] rd_mux = hit_p0 ? lvl0 :
                        hit_p1 ? lvl1 :
                        hit_p2 ? lvl2 :
                        hit_p4 ? lvl4 :
                        mod_src;

    pgp_rmw_alu u_alu (
        .op(cpu_op),
        .bit_idx(cpu_bit),
        .src(mod_src),
        .operand(cpu_wdata),
        .res(mod_res)
    );

    // ****************************************
    // Register file
    // ****************************************
    // Reserved bits are held at zero so a careless write cannot enable
    // a pull-up or open drain on a missing port.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pullup_enable_reg_r <= `PGP_RST_PU;
            port_open_drain_reg_r <= `PGP_RST_POM;
            pin_open_drain_reg_r <= `PGP_RST_POM;
        end else begin
            if (wr_pu) begin
                pullup_enable_reg_r <= mod_res & `PGP_MSK_PU;
            end
            if (wr_port_open_drain_reg) begin
                port_open_drain_reg_r <= mod_res & `PGP_MSK_PORT_OPEN_DRAIN_REG;
            end
            if (wr_pin_open_drain_reg) begin
                pin_open_drain_reg_r <= mod_res & `PGP_MSK_PIN_OPEN_DRAIN_REG;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata_r <= 8'h00;
        end else if (cpu_rd) begin
            cpu_rdata_r <= rd_mux;
        end
    end

    assign cpu_rdata = cpu_rdata_r;

    // ****************************************
    // Drive selection per port
    // ****************************************
    wire [7:0] od0 = {8{port_open_drain_reg_r[`PGP_BIT_POM_P0]}};
    wire [7:0] od1 = {8{port_open_drain_reg_r[`PGP_BIT_POM_P1]}};
    wire [7:0] od2 = pin_open_drain_reg_r & `PGP_MSK_PIN_OPEN_DRAIN_REG;

    // ****************************************
    // Port cells
    // ****************************************
    pgp_port_cell u_p0 (
        .mclk(mclk),
        .rst_b(rst_b),
        .lat_we(wr_p0),
        .lat_nxt(mod_res),
        .dir_we(wr_pm0),
        .dir_nxt(mod_res),
        .dir_fix(8'h00),
        .od_sel(od0),
        .pu_en(pullup_enable_reg_r[`PGP_BIT_PU_P0]),
        .pin_in(p0_in),
        .lat_q(lat0),
        .dir_q(dir0),
        .pin_lvl(lvl0),
        .pin_out(p0_out),
        .pin_oe(p0_oe),
        .pin_pu(p0_pu)
    );

    pgp_port_cell u_p1 (
        .mclk(mclk),
        .rst_b(rst_b),
        .lat_we(wr_p1),
        .lat_nxt(mod_res),
        .dir_we(wr_pm1),
        .dir_nxt(mod_res),
        .dir_fix(8'h00),
        .od_sel(od1),
        .pu_en(pullup_enable_reg_r[`PGP_BIT_PU_P1]),
        .pin_in(p1_in),
        .lat_q(lat1),
        .dir_q(dir1),
        .pin_lvl(lvl1),
        .pin_out(p1_out),
        .pin_oe(p1_oe),
        .pin_pu(p1_pu)
    );

    // Port 2 bit 7 is input only
    pgp_port_cell u_p2 (
        .mclk(mclk),
        .rst_b(rst_b),
        .lat_we(wr_p2),
        .lat_nxt(mod_res),
        .dir_we(wr_pm2),
        .dir_nxt(mod_res),
        .dir_fix(`PGP_FIX_DIR2),
        .od_sel(od2),
        .pu_en(pullup_enable_reg_r[`PGP_BIT_PU_P2]),
        .pin_in(p2_in),
        .lat_q(lat2),
        .dir_q(dir2),
        .pin_lvl(lvl2),
        .pin_out(p2_out),
        .pin_oe(p2_oe),
        .pin_pu(p2_pu)
    );

    pgp_port_cell u_p4 (
        .mclk(mclk),
        .rst_b(rst_b),
        .lat_we(wr_p4),
        .lat_nxt(mod_res),
        .dir_we(wr_pm4),
        .dir_nxt(mod_res),
        .dir_fix(8'h00),
        .od_sel(8'h00),
        .pu_en(pullup_enable_reg_r[`PGP_BIT_PU_P4]),
        .pin_in(p4_in),
        .lat_q(lat4),
        .dir_q(dir4),
        .pin_lvl(lvl4),
        .pin_out(p4_out),
        .pin_oe(p4_oe),
        .pin_pu(p4_pu)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_PU_OUTPUT_MODE: assert property (
        ((p0_pu & ~dir0) | (p1_pu & ~dir1) | (p2_pu & ~dir2) | (p4_pu & ~dir4)) == 8'h00
    ) else $error("pull-up connected on an output-mode pin");

    AST_PU_DISABLED: assert property (
        wr_pu && cpu_op == pgp_op_mov && cpu_wdata[`PGP_BIT_PU_P1] == 1'b0 |=> p1_pu == 8'h00
    ) else $error("cleared pull-up bit still connects port 1");

    AST_PU_ENABLED: assert property (
        wr_pu && cpu_op == pgp_op_mov && cpu_wdata[`PGP_BIT_PU_P0] |=> p0_pu == dir0
    ) else $error("set pull-up bit did not connect input pins");

    // Own disable so these run while reset is held; the first edge is skipped
    AST_RESET_CLEARS: assert property (
        @(posedge mclk) disable iff (1'b0)
        !rst_b ##1 !rst_b |-> pullup_enable_reg_r == `PGP_RST_PU && p0_pu == 8'h00
    ) else $error("pull-up enable not cleared in reset");

    AST_RESET_PUSH_PULL: assert property (
        @(posedge mclk) disable iff (1'b0)
        !rst_b ##1 !rst_b |-> (port_open_drain_reg_r | pin_open_drain_reg_r) == `PGP_RST_POM
                              && p0_oe == 8'h00
    ) else $error("open-drain select not cleared in reset");

    AST_PORT_OPEN_DRAIN: assert property (
        port_open_drain_reg_r[`PGP_BIT_POM_P1] |-> (p1_out & p1_oe) == 8'h00 && p1_oe == (~dir1 & ~lat1)
    ) else $error("port 1 open drain drives high");

    AST_PIN_OPEN_DRAIN: assert property (
        pin_open_drain_reg_r[6] && !dir2[6] && lat2[6] |-> !p2_oe[6] && p2_oe[4:0] == ~dir2[4:0]
    ) else $error("port 2 pin 6 open drain or neighbours wrong");

    AST_LATCH_WRITE: assert property (
        wr_p0 && cpu_op == pgp_op_mov |=> lat0 == $past(cpu_wdata)
            && p0_out == (port_open_drain_reg_r[`PGP_BIT_POM_P0] ? 8'h00 : lat0)
    ) else $error("port 0 write did not load latch");

    AST_LATCH_HOLDS: assert property (
        !wr_p2 |=> $stable(lat2)
    ) else $error("port 2 latch changed without a write");

    AST_READ_PINS: assert property (
        cpu_rd && hit_p1 |=> cpu_rdata == $past(lvl1) && $stable(lat1)
    ) else $error("port read not pin levels or latch disturbed");

    AST_BIT_SET: assert property (
        wr_p4 && cpu_op == pgp_op_set1 ##1 !wr_p4 |-> lat4[$past(cpu_bit, 1)] ##1 $stable(lat4)
    ) else $error("bit set on port 4 lost");

    AST_ARITH_OUT: assert property (
        wr_p4 && cpu_op == pgp_op_add && dir4 == 8'h00 |=> lat4 == 8'($past(lat4) + $past(cpu_wdata))
    ) else $error("output-mode add not on latch");

    AST_DIR_DRIVE: assert property (
        (p0_oe & dir0) == 8'h00 && (p4_oe == ~dir4) && dir2[7]
    ) else $error("direction does not gate output driver");

    COV_PU_ON: cover property (wr_pu ##1 p0_pu != 8'h00);
    COV_OD_LOW: cover property (port_open_drain_reg_r[0] && p0_oe != 8'h00);
    COV_BIT_OP: cover property (wr_p2 && cpu_op == pgp_op_clr1 && dir2 != 8'hff);
    COV_ARITH: cover property (wr_p0 && cpu_op == pgp_op_sub);
endmodule : pgp_gpio

// ### tb/pgp_board.sv
// Board model: resolves the level on each port pin from the chip's pad drive and the external drivers
`timescale 1ns/1ns
module pgp_board (
    input wire logic mclk,          // System clock
    input wire logic rst_b,         // Async reset, active low
    input wire logic [7:0] pad_out, // Chip pad value
    input wire logic [7:0] pad_oe,  // Chip pad enable
    input wire logic [7:0] pad_pu,  // Chip pull-up connect
    input wire logic [7:0] ext_val, // External driver value
    input wire logic [7:0] ext_en,  // External driver enable
    output logic [7:0] pin_in       // Resolved pin level
);
    logic [7:0] flt_r;
    // A floating pin must not settle to a neat value, so it toggles every cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flt_r <= 8'h55;
        end else begin
            flt_r <= ~flt_r;
        end
    end
    // Chip drive wins, then the board, then the pull-up; a released open-drain pin with no board driver or pull-up floats
    assign pin_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & pad_pu) |
                    (~pad_oe & ~ext_en & ~pad_pu & flt_r);
endmodule : pgp_board

// ### tb/port_pin_control_and_latch_tb.sv
// Testbench of the port pin control block: register access, pad drive, latch operations
`timescale 1ns/1ns
`include "pgp_map.svh"
module port_pin_control_and_latch_tb import pgp_pkg::*;;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    pgp_op_t cpu_op = pgp_op_mov;
    logic [2:0] cpu_bit = 3'h0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic [7:0] pin_in [4];
    logic [7:0] pout [4];
    logic [7:0] poe [4];
    logic [7:0] ppu [4];
    logic [7:0] ext_val [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ext_en [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    int n_errors = 0;
    int checked = 0;
    pgp_op_t ops [7] = '{pgp_op_add, pgp_op_sub, pgp_op_and, pgp_op_or, pgp_op_xor, pgp_op_clr1, pgp_op_set1};
    logic [7:0] opd [7] = '{8'h05, 8'h01, 8'h0f, 8'h30, 8'hff, 8'h00, 8'h00};
    logic [2:0] obit [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
    logic [7:0] oexp [7] = '{8'h15, 8'h14, 8'h04, 8'h34, 8'hcb, 8'hca, 8'hda};

    always #50 mclk = ~mclk;

    pgp_gpio dut (
        .mclk(mclk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_op(cpu_op), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .p0_in(pin_in[0]), .p0_out(pout[0]), .p0_oe(poe[0]), .p0_pu(ppu[0]),
        .p1_in(pin_in[1]), .p1_out(pout[1]), .p1_oe(poe[1]), .p1_pu(ppu[1]),
        .p2_in(pin_in[2]), .p2_out(pout[2]), .p2_oe(poe[2]), .p2_pu(ppu[2]),
        .p4_in(pin_in[3]), .p4_out(pout[3]), .p4_oe(poe[3]), .p4_pu(ppu[3])
    );

    for (genvar g = 0; g < 4; g++) begin : g_board
        pgp_board board (
            .mclk(mclk), .rst_b(rst_b), .pad_out(pout[g]), .pad_oe(poe[g]), .pad_pu(ppu[g]),
            .ext_val(ext_val[g]), .ext_en(ext_en[g]), .pin_in(pin_in[g])
        );
    end

    // ***************************************************************
    // Access tasks and comparison
    // ***************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input pgp_op_t op, input logic [2:0] b, input logic [7:0] d);
        @(posedge mclk);
        #10;
        cpu_addr = a;
        cpu_op = op;
        cpu_bit = b;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(posedge mclk);
        #10;
        cpu_wr = 1'b0;
    endtask : wr

    task automatic wrm(input logic [15:0] a, input logic [7:0] d);
        wr(a, pgp_op_mov, 3'h0, d);
    endtask : wrm

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        #10;
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(posedge mclk);
        #10;
        cpu_rd = 1'b0;
        chk(cpu_rdata, exp, "read data");
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    initial begin : watchdog
        #3000000;
        n_errors++;
        $display("MISMATCH at %0t: run did not finish", $time);
        end_sim();
    end

    // ***************************************************************
    // Test sequence
    // ***************************************************************
    initial begin
        repeat (16) @(posedge mclk);
        #10;
        rst_b = 1'b1;
        chk(poe[0] | poe[1] | poe[2] | poe[3], 8'h00, "reset oe");
        chk(ppu[0] | ppu[1] | ppu[2] | ppu[3], 8'h00, "reset pull-up");
        rd(`PGP_ADR_PU, 8'h00);
        rd(`PGP_ADR_PORT_OPEN_DRAIN_REG, 8'h00);
        rd(`PGP_ADR_PIN_OPEN_DRAIN_REG, 8'h00);
        rd(`PGP_ADR_PM0, 8'hff);
        rd(`PGP_ADR_PM2, 8'hff);
        // Pull-ups follow the enable bit and the input-mode bits only
        wrm(`PGP_ADR_PU, 8'h17);
        rd(`PGP_ADR_PU, 8'h17);
        chk(ppu[0] & ppu[1] & ppu[2] & ppu[3], 8'hff, "pull-up all inputs");
        wrm(`PGP_ADR_PM0, 8'h0f);
        chk(ppu[0], 8'h0f, "pull-up output bits");
        wr(`PGP_ADR_PU, pgp_op_clr1, 3'h0, 8'h00);
        chk(ppu[0], 8'h00, "pull-up disconnected");
        rd(`PGP_ADR_PU, 8'h16);
        // Latch in input mode keeps the value but drives nothing
        wrm(`PGP_ADR_PM0, 8'hff);
        wrm(`PGP_ADR_P0, 8'ha5);
        chk(poe[0], 8'h00, "input mode oe");
        wrm(`PGP_ADR_PM0, 8'h00);
        chk(pout[0], 8'ha5, "latch driven");
        chk(poe[0], 8'hff, "output mode oe");
        idle(3);
        rd(`PGP_ADR_P0, 8'ha5);
        chk(pout[0], 8'ha5, "latch after read");
        // Open-drain selection per port and per pin
        wrm(`PGP_ADR_PORT_OPEN_DRAIN_REG, 8'h03);
        rd(`PGP_ADR_PORT_OPEN_DRAIN_REG, 8'h03);
        chk(pout[0], 8'h00, "open drain value");
        chk(poe[0], 8'h5a, "open drain enable");
        chk(poe[1], 8'h00, "port 1 still inputs");
        wrm(`PGP_ADR_PORT_OPEN_DRAIN_REG, 8'h00);
        chk(poe[0], 8'hff, "push-pull again");
        wrm(`PGP_ADR_PM2, 8'h00);
        wrm(`PGP_ADR_P2, 8'hff);
        wrm(`PGP_ADR_PIN_OPEN_DRAIN_REG, 8'h60);
        rd(`PGP_ADR_PIN_OPEN_DRAIN_REG, 8'h60);
        chk(pout[2], 8'h9f, "pin open drain value");
        chk(poe[2], 8'h1f, "pin open drain enable");
        wr(`PGP_ADR_P2, pgp_op_clr1, 3'h5, 8'h00);
        chk(poe[2], 8'h3f, "pin open drain pulls low");
        // Bit set on a mixed port takes input-mode bits from the pins
        wrm(`PGP_ADR_PM1, 8'hf0);
        wrm(`PGP_ADR_P1, 8'h00);
        ext_val[1] = 8'ha0;
        ext_en[1] = 8'hf0;
        idle(3);
        wr(`PGP_ADR_P1, pgp_op_set1, 3'h0, 8'h00);
        chk(pout[1], 8'ha1, "bit set merges pins");
        chk(poe[1], 8'h0f, "mixed port enable");
        idle(3);
        rd(`PGP_ADR_P1, 8'ha1);
        // Arithmetic in output mode works on the latch
        wrm(`PGP_ADR_PM4, 8'h00);
        wrm(`PGP_ADR_P4, 8'h10);
        for (int i = 0; i < 7; i++) begin
            wr(`PGP_ADR_P4, ops[i], obit[i], opd[i]);
            chk(pout[3], oexp[i], "arithmetic result");
        end
        // Arithmetic in input mode: pins unchanged, latch takes pin level plus operand
        wrm(`PGP_ADR_PM4, 8'hff);
        ext_val[3] = 8'h3c;
        ext_en[3] = 8'hff;
        idle(3);
        wr(`PGP_ADR_P4, pgp_op_add, 3'h0, 8'h01);
        chk(poe[3], 8'h00, "input mode arithmetic oe");
        rd(`PGP_ADR_P4, 8'h3c);
        ext_en[3] = 8'h00;
        wrm(`PGP_ADR_PM4, 8'h00);
        chk(pout[3], 8'h3d, "latch after input arithmetic");
        // Unmapped place reads zero and ignores writes
        wrm(16'hff40, 8'h5a);
        rd(16'hff40, 8'h00);
        end_sim();
    end
endmodule : port_pin_control_and_latch_tb
